//--- logic/perf_sel_pkg.sv
package perf_sel_pkg;

    // register bus geometry, raw count width and threshold field width
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned COUNT_W       = 5;
    localparam int unsigned THRESH_W      = 8;

    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0]  OFF_EVSEL     = 8'h00;
    localparam logic [7:0]  OFF_COUNTER   = 8'h04;
    localparam logic [7:0]  OFF_STATUS    = 8'h08;

    // event select register field positions
    localparam int unsigned EVSEL_CODE_LSB   = 0;
    localparam int unsigned EVSEL_UMASK_LSB  = 8;
    localparam int unsigned EVSEL_ENABLE_BIT = 16;
    localparam int unsigned EVSEL_INVERT_BIT = 17;
    localparam int unsigned EVSEL_ALL_THREADS_ALLOWED_FLAG_BIT   = 18;
    localparam int unsigned EVSEL_THRESH_LSB = 24;

    // status register field positions
    localparam int unsigned STAT_MISUSE_BIT  = 0;
    localparam int unsigned STAT_KNOWN_BIT   = 1;
    localparam int unsigned STAT_ALLT_BIT    = 2;

    // reset values
    localparam logic [31:0] EVSEL_RESET   = 32'h0000_0000;
    localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;

    // event codes
    localparam logic [7:0]  EV_LD_BLOCKS    = 8'h03;
    localparam logic [7:0]  EV_DTLB_LOAD    = 8'h08;
    localparam logic [7:0]  EV_ALLOC_RECOV  = 8'h0D;
    localparam logic [7:0]  EV_UOPS_ISSUED  = 8'h0E;
    localparam logic [7:0]  EV_DIVIDER      = 8'h14;
    localparam logic [7:0]  EV_L2_REQ       = 8'h24;
    localparam logic [7:0]  EV_LLC          = 8'h2E;
    localparam logic [7:0]  EV_UNHALTED     = 8'h3C;
    localparam logic [7:0]  EV_L1D_PEND     = 8'h48;
    localparam logic [7:0]  EV_EPT          = 8'h4F;
    localparam logic [7:0]  EV_L1D_FILL     = 8'h51;
    localparam logic [7:0]  EV_RS_EVENTS    = 8'h5E;
    localparam logic [7:0]  EV_OFFCORE_OUT  = 8'h60;

    // unit masks
    localparam logic [7:0]  UM_00 = 8'h00;
    localparam logic [7:0]  UM_01 = 8'h01;
    localparam logic [7:0]  UM_02 = 8'h02;
    localparam logic [7:0]  UM_04 = 8'h04;
    localparam logic [7:0]  UM_08 = 8'h08;
    localparam logic [7:0]  UM_10 = 8'h10;
    localparam logic [7:0]  UM_20 = 8'h20;
    localparam logic [7:0]  UM_3F = 8'h3F;
    localparam logic [7:0]  UM_41 = 8'h41;
    localparam logic [7:0]  UM_4F = 8'h4F;
    localparam logic [7:0]  UM_EF = 8'hEF;

    localparam logic [7:0]  THRESH_ONE = 8'h01;

endpackage

//--- logic/qual_if.sv
`timescale 1ns/1ns
interface qual_if;
    logic [4:0] raw_count;
    logic [7:0] threshold;
    logic       invert;
    logic [4:0] increment;

    modport producer
    (
        output raw_count,
        output threshold,
        output invert,
        input  increment
    );

    modport qualifier
    (
        input  raw_count,
        input  threshold,
        input  invert,
        output increment
    );
endinterface

//--- logic/count_qualifier.sv
`timescale 1ns/1ns
module count_qualifier
(
    qual_if.qualifier q    // raw count in, qualified increment out
);
    import perf_sel_pkg::*;

    logic [7:0] raw_wide;
    logic       at_or_above;

    always_comb
    begin
        raw_wide    = {3'h0, q.raw_count};
        at_or_above = (raw_wide >= q.threshold);
        if (q.threshold == 8'h00)
        begin
            q.increment = q.raw_count;
        end
        else if (q.invert)
        begin
            q.increment = {4'h0, ~at_or_above};
        end
        else
        begin
            q.increment = {4'h0, at_or_above};
        end
    end
endmodule

//--- logic/core_perf_event_selector.sv
`timescale 1ns/1ns
module core_perf_event_selector
    import perf_sel_pkg::*;
(
    input  wire logic                               mclk,                      // core clock, 50 MHz
    input  wire logic                               reset,                     // synchronous, active high
    input  wire logic [perf_sel_pkg::ADDR_W-1:0]    reg_addr,                  // register byte address
    input  wire logic [perf_sel_pkg::DATA_W-1:0]    reg_wdata,                 // register write data
    input  wire logic                               reg_wr,                    // write strobe
    input  wire logic                               reg_rd,                    // read strobe
    output logic      [perf_sel_pkg::DATA_W-1:0]    reg_rdata,                 // read data, cycle after strobe
    output logic      [perf_sel_pkg::DATA_W-1:0]    counter_value,             // live counter
    input  wire logic                               ld_store_fwd_block,        // load blocked by store overlap
    input  wire logic                               ld_split_block,            // split load held off
    input  wire logic [2:0]                         page_miss_handler_load,    // handlers walking for loads
    input  wire logic                               alloc_recovery_this,       // allocator recovery, this thread
    input  wire logic                               alloc_recovery_any,        // allocator recovery, any thread
    input  wire logic [2:0]                         register_alias_table_issue, // micro-ops issued this cycle
    input  wire logic [1:0]                         address_compute_op_slow,   // slow ops allocated this cycle
    input  wire logic                               divider_active,            // divider busy
    input  wire logic                               l2_request,                // second-level request
    input  wire logic                               l2_miss,                   // second-level miss
    input  wire logic                               llc_reference,             // last-level reference
    input  wire logic                               llc_miss,                  // last-level miss
    input  wire logic                               unhalted_this,             // this thread unhalted
    input  wire logic                               unhalted_any,              // any thread unhalted
    input  wire logic                               xclk_tick,                 // crystal clock tick pulse
    input  wire logic [4:0]                         l1d_pending_this,          // outstanding misses, this thread
    input  wire logic [4:0]                         l1d_pending_any,           // outstanding misses, whole core
    input  wire logic                               fill_buffer_full,          // demand request found no entry
    input  wire logic [2:0]                         page_miss_handler_ept,     // handlers on nested walks
    input  wire logic                               l1d_fill,                  // line filled into first level
    input  wire logic                               reservation_station_empty, // station empty for thread
    input  wire logic [4:0]                         offcore_request_queue_rd,  // outstanding demand reads
    input  wire logic [4:0]                         read_for_ownership_out     // outstanding ownership reads
);

    qual_if qbus ();

    logic [31:0] evsel_q;
    logic [31:0] counter_q;
    logic [31:0] counter_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        misuse_q;
    logic        rs_empty_q;
    logic        known_q;

    logic [7:0]  event_code;
    logic [7:0]  unit_mask;
    logic        count_enable;
    logic        threshold_invert;
    logic        all_threads_qualifier;
    logic [7:0]  count_threshold;

    logic [4:0]  raw_count;
    logic        pair_known;
    logic        all_threads_allowed_flag;
    logic        empty_end_mode;
    logic        wr_evsel;
    logic        wr_counter;
    logic        wr_status;

    assign event_code            = evsel_q[EVSEL_CODE_LSB +: 8];
    assign unit_mask             = evsel_q[EVSEL_UMASK_LSB +: 8];
    assign count_enable          = evsel_q[EVSEL_ENABLE_BIT];
    assign threshold_invert      = evsel_q[EVSEL_INVERT_BIT];
    assign all_threads_qualifier = evsel_q[EVSEL_ALL_THREADS_ALLOWED_FLAG_BIT];
    assign count_threshold       = evsel_q[EVSEL_THRESH_LSB +: 8];

    assign wr_evsel   = reg_wr && (reg_addr == OFF_EVSEL);
    assign wr_counter = reg_wr && (reg_addr == OFF_COUNTER);
    assign wr_status  = reg_wr && (reg_addr == OFF_STATUS);

    // end of an empty period: station was empty last cycle and is not now
    assign empty_end_mode = (event_code == EV_RS_EVENTS) && (unit_mask == UM_01)
                            && (count_threshold == THRESH_ONE) && threshold_invert;

    always_comb
    begin
        raw_count                = 5'h00;
        pair_known               = 1'b1;
        all_threads_allowed_flag = 1'b0;
        case (event_code)
            EV_LD_BLOCKS:
            begin
                if (unit_mask == UM_02)
                begin
                    raw_count = {4'h0, ld_store_fwd_block};
                end
                else if (unit_mask == UM_08)
                begin
                    raw_count = {4'h0, ld_split_block};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_DTLB_LOAD:
            begin
                if (unit_mask == UM_10)
                begin
                    raw_count = {2'h0, page_miss_handler_load};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_ALLOC_RECOV:
            begin
                if (unit_mask == UM_01)
                begin
                    all_threads_allowed_flag = 1'b1;
                    raw_count = {4'h0, all_threads_qualifier ? alloc_recovery_any : alloc_recovery_this};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_UOPS_ISSUED:
            begin
                if (unit_mask == UM_01)
                begin
                    raw_count = {2'h0, register_alias_table_issue};
                end
                else if (unit_mask == UM_20)
                begin
                    raw_count = {3'h0, address_compute_op_slow};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_DIVIDER:
            begin
                if (unit_mask == UM_01)
                begin
                    raw_count = {4'h0, divider_active};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_L2_REQ:
            begin
                if (unit_mask == UM_3F)
                begin
                    raw_count = {4'h0, l2_miss};
                end
                else if (unit_mask == UM_EF)
                begin
                    raw_count = {4'h0, l2_request};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_LLC:
            begin
                if (unit_mask == UM_4F)
                begin
                    raw_count = {4'h0, llc_reference};
                end
                else if (unit_mask == UM_41)
                begin
                    raw_count = {4'h0, llc_miss};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_UNHALTED:
            begin
                all_threads_allowed_flag = 1'b1;
                if (unit_mask == UM_00)
                begin
                    raw_count = {4'h0, all_threads_qualifier ? unhalted_any : unhalted_this};
                end
                else if (unit_mask == UM_01)
                begin
                    raw_count = {4'h0, xclk_tick && (all_threads_qualifier ? unhalted_any : unhalted_this)};
                end
                else
                begin
                    pair_known               = 1'b0;
                    all_threads_allowed_flag = 1'b0;
                end
            end
            EV_L1D_PEND:
            begin
                if (unit_mask == UM_01)
                begin
                    all_threads_allowed_flag = 1'b1;
                    raw_count = all_threads_qualifier ? l1d_pending_any : l1d_pending_this;
                end
                else if (unit_mask == UM_02)
                begin
                    raw_count = {4'h0, fill_buffer_full};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_EPT:
            begin
                if (unit_mask == UM_10)
                begin
                    raw_count = {2'h0, page_miss_handler_ept};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_L1D_FILL:
            begin
                if (unit_mask == UM_01)
                begin
                    raw_count = {4'h0, l1d_fill};
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_RS_EVENTS:
            begin
                if (unit_mask == UM_01)
                begin
                    if (empty_end_mode)
                    begin
                        raw_count = {4'h0, rs_empty_q && !reservation_station_empty};
                    end
                    else
                    begin
                        raw_count = {4'h0, reservation_station_empty};
                    end
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            EV_OFFCORE_OUT:
            begin
                if (unit_mask == UM_01)
                begin
                    raw_count = offcore_request_queue_rd;
                end
                else if (unit_mask == UM_04)
                begin
                    raw_count = read_for_ownership_out;
                end
                else
                begin
                    pair_known = 1'b0;
                end
            end
            default:
            begin
                pair_known = 1'b0;
            end
        endcase
    end

    assign qbus.raw_count = raw_count;
    assign qbus.threshold = count_threshold;
    // edge mode already yields one per period end, so the invert must not flip it
    assign qbus.invert    = threshold_invert && !empty_end_mode;

    count_qualifier u_qual
    (
        .q (qbus.qualifier)
    );

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            evsel_q <= EVSEL_RESET;
        end
        else if (wr_evsel)
        begin
            evsel_q <= reg_wdata;
        end
    end

    // software preset wins over a same-cycle increment
    always_comb
    begin
        counter_d = counter_q;
        if (wr_counter)
        begin
            counter_d = reg_wdata;
        end
        else if (count_enable)
        begin
            counter_d = counter_q + {27'h0, qbus.increment};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            counter_q <= COUNTER_RESET;
        end
        else
        begin
            counter_q <= counter_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rs_empty_q <= 1'b0;
        end
        else
        begin
            rs_empty_q <= reservation_station_empty;
        end
    end

    // the far side should never do this; flag it rather than trust it, set beats clear
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            misuse_q <= 1'b0;
        end
        else if (count_enable && all_threads_qualifier && !all_threads_allowed_flag)
        begin
            misuse_q <= 1'b1;
        end
        else if (wr_status && reg_wdata[STAT_MISUSE_BIT])
        begin
            misuse_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            known_q <= 1'b0;
        end
        else
        begin
            known_q <= pair_known;
        end
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_EVSEL:
                begin
                    rdata_d = evsel_q;
                end
                OFF_COUNTER:
                begin
                    rdata_d = counter_q;
                end
                OFF_STATUS:
                begin
                    rdata_d[STAT_MISUSE_BIT] = misuse_q;
                    rdata_d[STAT_KNOWN_BIT]  = known_q;
                    rdata_d[STAT_ALLT_BIT]   = all_threads_allowed_flag;
                end
                default:
                begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata     = rdata_q;
    assign counter_value = counter_q;

endmodule

//--- dv/event_source.sv
`timescale 1ns/1ns
module event_source
(
    input  wire logic [22:0] mask, // raised sources
    input  wire logic [4:0]  lvl,  // level or count
    output logic      [45:0] ev    // packed, first lowest
);
    // source widths, selector port order
    localparam int W [23] = '{1, 1, 3, 1, 1, 3, 2, 1, 1, 1, 1, 1, 1, 1, 1, 5, 5, 1, 3, 1, 1, 5, 5};

    // quiet sources read zero
    always_comb
    begin
        int off;
        off = 0;
        ev  = '0;
        for (int i = 0; i < 23; i++)
        begin
            for (int b = 0; b < W[i]; b++)
                ev[off + b] = mask[i] & lvl[b];
            off += W[i];
        end
    end
endmodule

//--- dv/perf_sel_props.sv
`timescale 1ns/1ns
module perf_sel_props
    import perf_sel_pkg::*;
(
    input wire logic        mclk,                      // core clock
    input wire logic        reset,                     // sync reset
    input wire logic [7:0]  reg_addr,                  // address
    input wire logic [31:0] reg_wdata,                 // write data
    input wire logic        reg_wr,                    // write strobe
    input wire logic        reg_rd,                    // read strobe
    input wire logic [31:0] reg_rdata,                 // read data
    input wire logic [31:0] counter_value,             // live counter
    input wire logic        ld_store_fwd_block,        // blocked load
    input wire logic [2:0]  page_miss_handler_load,    // load walks
    input wire logic        alloc_recovery_any,        // any recovery
    input wire logic [2:0]  register_alias_table_issue, // issued ops
    input wire logic        divider_active,            // divider busy
    input wire logic        unhalted_this,             // unhalted
    input wire logic        xclk_tick,                 // crystal tick
    input wire logic        l1d_fill,                  // line fill
    input wire logic        reservation_station_empty, // station empty
    input wire logic [4:0]  offcore_request_queue_rd   // demand reads
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    logic [31:0] sel_q;

    // shadow of the select register, so each check knows the live pair
    always_ff @(posedge mclk)
    begin
        if (reset)
            sel_q <= 32'h0000_0000;
        else if (reg_wr && reg_addr == OFF_EVSEL)
            sel_q <= reg_wdata;
    end

    function automatic logic cfg(input logic [31:0] v);
        return !reg_wr && sel_q[31:24] == v[31:24] && sel_q[18:0] == v[18:0];
    endfunction

    chk_fill_count: assert property
        (cfg(32'h0001_0151) |=> counter_value == $past(counter_value) + $past(l1d_fill))
        else $error("line fill not counted");
    chk_issue_add: assert property
        (cfg(32'h0001_010E) |=> counter_value == $past(counter_value) + $past(register_alias_table_issue))
        else $error("issued ops not added");
    chk_queue_six: assert property
        (cfg(32'h0601_0160) |=>
            counter_value == $past(counter_value) + ($past(offcore_request_queue_rd) >= 5'h06))
        else $error("six read threshold wrong");
    chk_divider_busy: assert property
        (cfg(32'h0001_0114) |=> counter_value == $past(counter_value) + $past(divider_active))
        else $error("divider cycles wrong");
    chk_store_block: assert property
        (cfg(32'h0001_0203) |=> counter_value == $past(counter_value) + $past(ld_store_fwd_block))
        else $error("blocked loads wrong");
    chk_walk_cycles: assert property
        (cfg(32'h0101_1008) |=>
            counter_value == $past(counter_value) + ($past(page_miss_handler_load) != 3'h0))
        else $error("walk cycles wrong");
    chk_empty_end: assert property
        (cfg(32'h0103_015E) |=> counter_value == $past(counter_value)
            + ($past(reservation_station_empty, 2) && !$past(reservation_station_empty)))
        else $error("empty ends wrong");
    chk_xclk_unhalt: assert property
        (cfg(32'h0001_013C) |=>
            counter_value == $past(counter_value) + ($past(xclk_tick) && $past(unhalted_this)))
        else $error("crystal ticks wrong");
    chk_recov_any: assert property
        (cfg(32'h0005_010D) |=> counter_value == $past(counter_value) + $past(alloc_recovery_any))
        else $error("any thread recovery wrong");
    chk_read_idle: assert property
        (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
endmodule

bind core_perf_event_selector perf_sel_props chk (.*);

//--- dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    import perf_sel_pkg::*;
    typedef struct packed {
        logic [7:0]  code;
        logic [7:0]  um;
        logic [7:0]  thr;
        logic [1:0]  fl;
        logic [22:0] mask;
        logic [4:0]  lvl;
        logic [7:0]  inc;
    } row_type;
    logic        mclk, reset, reg_wr, reg_rd;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, counter_value, c0, d;
    logic [22:0] mask;
    logic [4:0]  lvl;
    logic [45:0] ev;
    int          n_fail, cmp_count;
    row_type     rows [29];

    core_perf_event_selector uut
    (
        .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .counter_value,
        .ld_store_fwd_block(ev[0]), .ld_split_block(ev[1]), .page_miss_handler_load(ev[4:2]),
        .alloc_recovery_this(ev[5]), .alloc_recovery_any(ev[6]), .register_alias_table_issue(ev[9:7]),
        .address_compute_op_slow(ev[11:10]), .divider_active(ev[12]), .l2_request(ev[13]), .l2_miss(ev[14]),
        .llc_reference(ev[15]), .llc_miss(ev[16]), .unhalted_this(ev[17]), .unhalted_any(ev[18]),
        .xclk_tick(ev[19]), .l1d_pending_this(ev[24:20]), .l1d_pending_any(ev[29:25]),
        .fill_buffer_full(ev[30]), .page_miss_handler_ept(ev[33:31]), .l1d_fill(ev[34]),
        .reservation_station_empty(ev[35]), .offcore_request_queue_rd(ev[40:36]),
        .read_for_ownership_out(ev[45:41])
    );
    event_source src (.mask, .lvl, .ev);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // hang guard
    initial
    begin
        #200000;
        n_fail++;
        $display("BAD run time expected 0 seen 1");
        complete_run;
    end

    initial
    begin
        reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
        mask = 23'h0; lvl = 5'h00; n_fail = 0; cmp_count = 0;
        rows = '{
            '{8'h03,8'h02,8'h00,2'h0,23'h1,5'h01,8'h01},
            '{8'h03,8'h08,8'h00,2'h0,23'h2,5'h01,8'h01},
            '{8'h08,8'h10,8'h00,2'h0,23'h4,5'h03,8'h03},
            '{8'h08,8'h10,8'h01,2'h0,23'h4,5'h03,8'h01},
            '{8'h0D,8'h01,8'h00,2'h0,23'h8,5'h01,8'h01},
            '{8'h0D,8'h01,8'h00,2'h0,23'h10,5'h01,8'h00},
            '{8'h0D,8'h01,8'h00,2'h2,23'h10,5'h01,8'h01},
            '{8'h0E,8'h01,8'h00,2'h0,23'h20,5'h05,8'h05},
            '{8'h0E,8'h01,8'h01,2'h1,23'h20,5'h00,8'h01},
            '{8'h0E,8'h20,8'h00,2'h0,23'h40,5'h03,8'h03},
            '{8'h14,8'h01,8'h00,2'h0,23'h80,5'h01,8'h01},
            '{8'h24,8'h3F,8'h00,2'h0,23'h200,5'h01,8'h01},
            '{8'h24,8'hEF,8'h00,2'h0,23'h100,5'h01,8'h01},
            '{8'h2E,8'h4F,8'h00,2'h0,23'h400,5'h01,8'h01},
            '{8'h2E,8'h41,8'h00,2'h0,23'h800,5'h01,8'h01},
            '{8'h3C,8'h00,8'h00,2'h0,23'h1000,5'h01,8'h01},
            '{8'h3C,8'h01,8'h00,2'h0,23'h5000,5'h01,8'h01},
            '{8'h3C,8'h01,8'h00,2'h0,23'h4000,5'h01,8'h00},
            '{8'h48,8'h01,8'h00,2'h0,23'h8000,5'h07,8'h07},
            '{8'h48,8'h01,8'h01,2'h2,23'h10000,5'h07,8'h01},
            '{8'h48,8'h02,8'h00,2'h0,23'h20000,5'h01,8'h01},
            '{8'h4F,8'h10,8'h00,2'h0,23'h40000,5'h05,8'h05},
            '{8'h51,8'h01,8'h00,2'h0,23'h80000,5'h01,8'h01},
            '{8'h5E,8'h01,8'h00,2'h0,23'h100000,5'h01,8'h01},
            '{8'h60,8'h01,8'h06,2'h0,23'h200000,5'h06,8'h01},
            '{8'h60,8'h01,8'h06,2'h0,23'h200000,5'h05,8'h00},
            '{8'h60,8'h04,8'h00,2'h0,23'h400000,5'h09,8'h09},
            '{8'h60,8'h04,8'h01,2'h0,23'h400000,5'h09,8'h01},
            '{8'h07,8'h01,8'h00,2'h0,23'h7FFFFF,5'h1F,8'h00}
        };
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        #1 chk("counter after reset", counter_value, COUNTER_RESET);
        rd(OFF_EVSEL, d);
        chk("select reset", d, EVSEL_RESET);
        $display("reset test done");
        foreach (rows[i])
        begin
            @(posedge mclk);
            mask <= rows[i].mask;
            lvl  <= rows[i].lvl;
            wr(OFF_EVSEL, {rows[i].thr, 5'h00, rows[i].fl, 1'b1, rows[i].um, rows[i].code});
            repeat (2) @(posedge mclk);
            #1 c0 = counter_value;
            repeat (4) @(posedge mclk);
            #1 chk("event count", counter_value - c0, {22'h0, rows[i].inc, 2'h0});
        end
        $display("event table done");
        @(posedge mclk);
        mask <= 23'h100000;
        lvl  <= 5'h01;
        wr(OFF_EVSEL, 32'h0103_015E);
        repeat (2) @(posedge mclk);
        #1 c0 = counter_value;
        repeat (2)
        begin
            @(posedge mclk);
            mask <= 23'h000000;
            repeat (2) @(posedge mclk);
            mask <= 23'h100000;
        end
        repeat (2) @(posedge mclk);
        #1 chk("empty ends", counter_value - c0, 32'h0000_0002);
        $display("empty end test done");
        // all-threads set on a pair that forbids it, on purpose
        wr(OFF_EVSEL, 32'h0005_010E);
        rd(OFF_STATUS, d);
        chk("misuse flag", d & 32'h0000_0007, 32'h0000_0003);
        wr(OFF_EVSEL, 32'h00E0_0000);
        wr(OFF_STATUS, 32'h0000_0001);
        rd(OFF_STATUS, d);
        chk("misuse clear", d & 32'h0000_0001, 32'h0000_0000);
        rd(OFF_EVSEL, d);
        chk("select stored", d, 32'h00E0_0000);
        $display("misuse test done");
        @(posedge mclk);
        mask <= 23'h080000;
        wr(OFF_EVSEL, 32'h0001_0151);
        wr(OFF_COUNTER, 32'hFFFF_FFFF);
        #1 chk("counter write", counter_value, 32'hFFFF_FFFF);
        @(posedge mclk);
        #1 chk("counter wrap", counter_value, 32'h0000_0000);
        rd(8'h0C, d);
        chk("unmapped read", d, 32'h0000_0000);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        #1 chk("counter mid reset", counter_value, COUNTER_RESET);
        $display("wrap and reset test done");
        complete_run;
    end
endmodule
